//--- rtl/serial_pins_defines.vh
// Constants for the serial channel pin interface
`ifndef SERIAL_PINS_DEFINES_VH
`define SERIAL_PINS_DEFINES_VH
`define MODE_ASYNC 2'h0
`define MODE_SYNC 2'h1
`define ST_IDLE 2'h0
`define ST_START 2'h1
`define ST_DATA 2'h2
`define ST_STOP 2'h3
`define DATA_BITS 4'h8
`define DIV_RESET 16'h000f
`endif

//--- rtl/serial_channel_pin_interface.v
// Pin-level serial channels with clear-to-send, baud clock and port sharing
`timescale 1ns/100ps
// Contract
// R1: Transmission waits while the channel's clear-to-send input is deasserted.
// R2: Baud clock may come from the external baud clock input instead.
// R3: Far end keeps external baud clock at most half the processor clock.
// R4: Synchronous mode drives a shift clock on the transmit pin.
// R5: Synchronous mode receive pin becomes the data output while transmitting.
// R6: Channel 1 transmit-complete output pulses when a transmission finishes.
// R7: Channel 1 receive-complete output pulses when a character is received.
// R8: Completion outputs share pins with output-only port bits, by selection.
// R9: Serial pins share with bidirectional port bits, selected by configuration.
// R10: External baud clock is synchronised and edge detected before use.
`include "serial_pins_defines.vh"

// ============================================================
// One serial channel
module serial_chan #(
    parameter DIV_W = 16
) (
    input wire clk,
    input wire reset,
    input wire sync_mode,
    input wire use_ext_clk,
    input wire [DIV_W-1:0] divisor,
    input wire ext_clk_raw,
    input wire cts_n_raw,
    input wire rx_raw,
    input wire tx_start,
    input wire [7:0] tx_data,
    output wire tx_busy,
    output reg [7:0] rx_data_q,
    output reg tx_done_q,
    output reg rx_done_q,
    output reg tx_pin_q,
    output reg rx_pin_out_q,
    output reg rx_pin_oe_n_q
);
    reg [2:0] ext_q;
    reg [1:0] cts_q;
    reg [1:0] rxs_q;
    reg [DIV_W-1:0] cnt_q;
    reg [1:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg [3:0] ph_q;
    reg [1:0] rst_q;
    reg [3:0] rbit_q;
    reg [3:0] rph_q;
    reg [7:0] rsh_q;
    reg sclk_q;
    reg pend_q;
    reg [7:0] pdat_q;
    wire ext_edge;
    wire tick;
    wire cts_ok;
    // ============================================================
    // Input synchronisers
    always @(posedge clk)
    begin
        if (reset)
        begin
            ext_q <= 3'h0;
            cts_q <= 2'h3;
            rxs_q <= 2'h3;
        end
        else
        begin
            ext_q <= {ext_q[1:0], ext_clk_raw}; // [R10]
            cts_q <= {cts_q[0], cts_n_raw};
            rxs_q <= {rxs_q[0], rx_raw};
        end
    end
    assign ext_edge = ext_q[1] & ~ext_q[2]; // [R10]
    assign cts_ok = ~cts_q[1];
    // ============================================================
    // Baud generator, internal or external source
    assign tick = (cnt_q == {DIV_W{1'b0}}) && (use_ext_clk ? ext_edge : 1'b1); // [R2]
    always @(posedge clk)
    begin
        if (reset)
            cnt_q <= {DIV_W{1'b0}};
        else if (use_ext_clk ? ext_edge : 1'b1) // [R2]
            cnt_q <= (cnt_q == {DIV_W{1'b0}}) ? divisor : cnt_q - 1'b1;
    end
    // ============================================================
    // Transmitter
    assign tx_busy = pend_q | (st_q != `ST_IDLE);
    always @(posedge clk)
    begin
        if (reset)
        begin
            st_q <= `ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ph_q <= 4'h0;
            pend_q <= 1'b0;
            pdat_q <= 8'h00;
            tx_pin_q <= 1'b1;
            sclk_q <= 1'b1;
            rx_pin_out_q <= 1'b1;
            rx_pin_oe_n_q <= 1'b1;
            tx_done_q <= 1'b0;
        end
        else
        begin
            tx_done_q <= 1'b0;
            if (tx_start && !tx_busy)
            begin
                pend_q <= 1'b1;
                pdat_q <= tx_data;
            end
            if (tick)
            begin
                case (st_q)
                `ST_IDLE:
                begin
                    tx_pin_q <= 1'b1;
                    rx_pin_oe_n_q <= 1'b1;
                    if (pend_q && cts_ok) // [R1]
                    begin
                        pend_q <= 1'b0;
                        sh_q <= pdat_q;
                        bit_q <= 4'h0;
                        ph_q <= 4'h0;
                        st_q <= sync_mode ? `ST_DATA : `ST_START;
                        if (sync_mode)
                        begin
                            rx_pin_oe_n_q <= 1'b0; // [R5]
                            rx_pin_out_q <= pdat_q[0]; // [R5]
                            tx_pin_q <= 1'b0; // [R4]
                        end
                        else
                            tx_pin_q <= 1'b0;
                    end
                end
                `ST_START:
                begin
                    st_q <= `ST_DATA;
                    tx_pin_q <= sh_q[0];
                end
                `ST_DATA:
                begin
                    if (sync_mode)
                    begin
                        tx_pin_q <= ~tx_pin_q; // [R4]
                        if (tx_pin_q)
                        begin
                            sh_q <= {1'b1, sh_q[7:1]};
                            rx_pin_out_q <= sh_q[1]; // [R5]
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == `DATA_BITS - 4'h1)
                                st_q <= `ST_STOP;
                        end
                    end
                    else
                    begin
                        sh_q <= {1'b1, sh_q[7:1]};
                        tx_pin_q <= sh_q[1];
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `DATA_BITS - 4'h1)
                        begin
                            tx_pin_q <= 1'b1;
                            st_q <= `ST_STOP;
                        end
                    end
                end
                `ST_STOP:
                begin
                    tx_pin_q <= 1'b1;
                    rx_pin_oe_n_q <= 1'b1;
                    st_q <= `ST_IDLE;
                    tx_done_q <= 1'b1; // [R6]
                end
                default: st_q <= `ST_IDLE;
                endcase
            end
        end
    end
    // ============================================================
    // Asynchronous receiver, one sample per baud tick
    always @(posedge clk)
    begin
        if (reset)
        begin
            rst_q <= `ST_IDLE;
            rbit_q <= 4'h0;
            rph_q <= 4'h0;
            rsh_q <= 8'h00;
            rx_data_q <= 8'h00;
            rx_done_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            if (tick && !sync_mode)
            begin
                case (rst_q)
                `ST_IDLE:
                    if (!rxs_q[1])
                    begin
                        rst_q <= `ST_DATA;
                        rbit_q <= 4'h0;
                    end
                `ST_DATA:
                begin
                    rsh_q <= {rxs_q[1], rsh_q[7:1]};
                    rbit_q <= rbit_q + 4'h1;
                    if (rbit_q == `DATA_BITS - 4'h1)
                        rst_q <= `ST_STOP;
                end
                `ST_STOP:
                begin
                    rst_q <= `ST_IDLE;
                    rx_data_q <= rsh_q;
                    rx_done_q <= 1'b1; // [R7]
                end
                default: rst_q <= `ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ============================================================
// Two channels with pin sharing
module serial_channel_pin_interface #(
    parameter DIV_W = 16
) (
    input wire clk,
    input wire reset,
    input wire [1:0] sync_mode,
    input wire [1:0] use_ext_clk,
    input wire [DIV_W-1:0] divisor_ch0,
    input wire [DIV_W-1:0] divisor_ch1,
    input wire [1:0] tx_start,
    input wire [7:0] tx_data_ch0,
    input wire [7:0] tx_data_ch1,
    output wire [1:0] tx_busy,
    output wire [7:0] rx_data_ch0,
    output wire [7:0] rx_data_ch1,
    output wire [1:0] tx_done,
    output wire [1:0] rx_done,
    input wire [7:0] ioport_serial_sel,
    input wire [7:0] ioport_out,
    input wire [7:0] ioport_dir_out,
    input wire [7:0] ioport_pin_in,
    output wire [7:0] ioport_pin_out,
    output wire [7:0] ioport_pin_oe_n,
    input wire [1:0] outport_serial_sel,
    input wire [1:0] outport_out,
    output reg [1:0] outport_pin_q
);
    wire [7:0] txp;
    wire [7:0] rxo;
    wire [7:0] rxoe_n;
    wire [1:0] txq;
    wire [1:0] rxq;
    wire [1:0] rxoen;
    // Pin order: c7 clear_to_send_ch1, c6 baud1, c5 tx1, c4 rx1, c3 clear_to_send_ch0, c2 baud0, c1 tx0, c0 rx0
    serial_chan #(.DIV_W(DIV_W)) ch0 (
        .clk(clk), .reset(reset), .sync_mode(sync_mode[0]), .use_ext_clk(use_ext_clk[0]),
        .divisor(divisor_ch0), .ext_clk_raw(ioport_pin_in[2]),
        .cts_n_raw(ioport_serial_sel[3] ? ioport_pin_in[3] : 1'b0),
        .rx_raw(ioport_pin_in[0]), .tx_start(tx_start[0]), .tx_data(tx_data_ch0),
        .tx_busy(tx_busy[0]), .rx_data_q(rx_data_ch0), .tx_done_q(tx_done[0]),
        .rx_done_q(rx_done[0]), .tx_pin_q(txq[0]), .rx_pin_out_q(rxq[0]),
        .rx_pin_oe_n_q(rxoen[0]));
    serial_chan #(.DIV_W(DIV_W)) ch1 (
        .clk(clk), .reset(reset), .sync_mode(sync_mode[1]), .use_ext_clk(use_ext_clk[1]),
        .divisor(divisor_ch1), .ext_clk_raw(ioport_pin_in[6]),
        .cts_n_raw(ioport_serial_sel[7] ? ioport_pin_in[7] : 1'b0),
        .rx_raw(ioport_pin_in[4]), .tx_start(tx_start[1]), .tx_data(tx_data_ch1),
        .tx_busy(tx_busy[1]), .rx_data_q(rx_data_ch1), .tx_done_q(tx_done[1]),
        .rx_done_q(rx_done[1]), .tx_pin_q(txq[1]), .rx_pin_out_q(rxq[1]),
        .rx_pin_oe_n_q(rxoen[1]));
    // Serial drive: tx pins always drive, rx pins only in sync transmit
    assign txp = {1'b0, 1'b0, txq[1], rxq[1], 1'b0, 1'b0, txq[0], rxq[0]};
    assign rxoe_n = {1'b1, 1'b1, 1'b0, rxoen[1], 1'b1, 1'b1, 1'b0, rxoen[0]};
    assign rxo = txp;
    assign ioport_pin_out = (ioport_serial_sel & rxo) | (~ioport_serial_sel & ioport_out); // [R9]
    assign ioport_pin_oe_n = (ioport_serial_sel & rxoe_n) |
        (~ioport_serial_sel & ~ioport_dir_out); // [R9]
    always @(posedge clk)
    begin
        if (reset)
            outport_pin_q <= 2'h0;
        else
            outport_pin_q <= (outport_serial_sel & {tx_done[1], rx_done[1]}) |
                (~outport_serial_sel & outport_out); // [R8]
    end
endmodule

//--- testbench/serial_pins_props.sv
// Assertion checker for the serial pin interface
`timescale 1ns/100ps
module serial_pins_props (
    input wire clk,
    input wire reset,
    input wire [1:0] sync_mode,
    input wire [1:0] use_ext_clk,
    input wire [1:0] tx_start,
    input wire [1:0] tx_busy,
    input wire [1:0] tx_done,
    input wire [1:0] rx_done,
    input wire [7:0] ioport_serial_sel,
    input wire [7:0] ioport_dir_out,
    input wire [7:0] ioport_pin_in,
    input wire [7:0] ioport_pin_out,
    input wire [7:0] ioport_pin_oe_n,
    input wire [1:0] outport_serial_sel,
    input wire [1:0] outport_out,
    input wire [1:0] outport_pin_q
);
    // ========
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    cts_hold_a: assert property (
        ioport_pin_in[7] [*3] ##0 (tx_start[1] && !tx_busy[1] && ioport_serial_sel[7]
        && !sync_mode[1]) ##1 ioport_pin_in[7] [*4] |-> ioport_pin_out[5])
        else $error("tx left idle");
    ext_tick_a: assert property (
        (use_ext_clk[1] && ioport_serial_sel[6] && !sync_mode[1]
        && $stable(ioport_pin_in[6])) [*7] |=> $stable(ioport_pin_out[5]))
        else $error("tx moved without baud edge");
    rx_drive_a: assert property (
        !ioport_pin_oe_n[4] && ioport_serial_sel[4]
        |-> sync_mode[1] && (tx_busy[1] || $past(tx_busy[1])))
        else $error("rx pin driven");
    tx_pulse_a: assert property (
        tx_done[1] |-> $past(tx_busy[1]) ##1 !tx_done[1]) else $error("tx done pulse");
    tx_out_a: assert property (
        outport_serial_sel[1] && tx_done[1] |=> outport_pin_q[1] ##1 !outport_pin_q[1])
        else $error("tx done pin");
    rx_out_a: assert property (
        outport_serial_sel[0] && rx_done[1] |=> outport_pin_q[0] ##1 !outport_pin_q[0])
        else $error("rx done pin");
    port_out_a: assert property (
        !outport_serial_sel[1] && !$past(outport_serial_sel[1]) && !$past(reset)
        |-> outport_pin_q[1] == $past(outport_out[1])) else $error("port bit");
    port_dir_a: assert property (
        ioport_serial_sel[3:0] == 4'h0 && $stable(ioport_dir_out[3:0]) && !$past(reset)
        |-> ioport_pin_oe_n[3:0] == ~ioport_dir_out[3:0]) else $error("port dir");
    c_tx: cover property (tx_done[1]);
    c_rx: cover property (rx_done[1]);
    c_sy: cover property (sync_mode[1] && !ioport_pin_oe_n[4]);
endmodule
bind serial_channel_pin_interface serial_pins_props props (.*);

//--- testbench/serial_far_end.sv
// Far-end serial device model
`timescale 1ns/100ps
module serial_far_end (
    input wire run,
    input wire tx_line,
    output reg baud_clk,
    output reg rx_line
);
    // ========
    // Baud clock, still when idle
    initial
    begin
        baud_clk = 0;
        rx_line = 1;
        forever #200 baud_clk = run & ~baud_clk;
    end
    task send_byte(input [7:0] d);
        integer i;
        reg [9:0] f;
        begin
            f = {1'b1, d, 1'b0};
            for (i = 0; i < 10; i = i + 1)
            begin
                @(negedge baud_clk);
                #100 rx_line = f[i];
            end
        end
    endtask
    task recv_byte(output [7:0] d);
        integer i;
        begin
            i = 0;
            while (tx_line !== 1'b0 && i < 40)
            begin
                @(posedge baud_clk);
                i = i + 1;
            end
            for (i = 0; i < 8; i = i + 1)
            begin
                @(posedge baud_clk);
                d[i] = tx_line;
            end
        end
    endtask
endmodule

//--- testbench/testbench.sv
// Testbench for the serial pin interface
`timescale 1ns/100ps
module testbench;
    reg clk = 0, reset = 1, cts_n = 1, run = 0;
    reg [1:0] sync_mode = 0, use_ext_clk = 2'h3, tx_start = 0;
    reg [1:0] outport_serial_sel = 0, outport_out = 0;
    reg [15:0] divisor_ch0 = 0, divisor_ch1 = 0;
    reg [7:0] tx_data_ch0 = 0, tx_data_ch1 = 0, ioport_serial_sel = 8'hf0;
    reg [7:0] ioport_out = 0, ioport_dir_out = 0, d;
    wire [1:0] tx_busy, tx_done, rx_done, outport_pin_q;
    wire [7:0] rx_data_ch0, rx_data_ch1, ioport_pin_out, ioport_pin_oe_n, ioport_pin_in;
    wire bclk, rxl;
    integer err_count = 0, total_checks = 0, n, tog;
    reg drove, last;
    assign ioport_pin_in = {cts_n, bclk, ioport_pin_oe_n[5] | ioport_pin_out[5],
        ioport_pin_oe_n[4] ? rxl : ioport_pin_out[4], ioport_pin_out[3:0] | ioport_pin_oe_n[3:0]};
    serial_channel_pin_interface uut (.*);
    serial_far_end far (.run(run), .tx_line(ioport_pin_in[5]), .baud_clk(bclk), .rx_line(rxl));
    initial forever #25 clk = ~clk;
    // ========
    // Checking
    task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
        begin
            total_checks = total_checks + 1;
            if (s !== e)
            begin
                err_count = err_count + 1;
                $display("MISMATCH %0s exp %0h got %0h", nm, e, s);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d errors %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task wait_done(input integer lim);
        begin
            n = 0;
            while ((tx_done[1] | rx_done[1]) !== 1'b1 && n < lim)
            begin
                @(negedge clk);
                n = n + 1;
                tog = tog + (ioport_pin_out[5] != last);
                last = ioport_pin_out[5];
                drove = drove | ~ioport_pin_oe_n[4];
            end
        end
    endtask
    task start_tx(input [7:0] v, input [1:0] m);
        begin
            @(posedge clk);
            sync_mode <= m;
            tx_data_ch1 <= v;
            tx_start <= 2'h2;
            @(posedge clk);
            tx_start <= 2'h0;
            tog = 0;
            drove = 0;
            last = ioport_pin_out[5];
        end
    endtask
    // ========
    // Scenarios
    task t_gpio;
        begin
            ioport_dir_out <= 8'h05;
            ioport_out <= 8'h0f;
            outport_out <= 2'h2;
            repeat (3) @(negedge clk);
            chk(ioport_pin_oe_n[3:0], 4'ha, "oe_n");
            chk(ioport_pin_out[2:0] & 3'h5, 3'h5, "pout");
            chk(outport_pin_q, 2'h2, "outport");
            chk(tx_busy[0], 1'b0, "busy0");
            chk({tx_done[0], rx_done[0]}, 2'h0, "done0");
            chk(rx_data_ch0, 8'h00, "rxdata0");
            outport_serial_sel <= 2'h3;
        end
    endtask
    task t_tx;
        begin
            start_tx(8'ha5, 2'h0);
            run <= 1;
            repeat (96) @(negedge clk);
            chk(ioport_pin_out[5], 1, "held");
            chk(tx_busy[1], 1, "busy");
            @(posedge clk);
            cts_n <= 0;
            far.recv_byte(d);
            chk(d, 8'ha5, "txbyte");
            wait_done(400);
            chk(tx_done[1], 1, "txdone");
            @(negedge clk);
            chk(outport_pin_q[1], 1, "txpin");
        end
    endtask
    task t_rx;
        fork
            far.send_byte(8'h3c);
            begin
                wait_done(400);
                chk(rx_data_ch1, 8'h3c, "rxbyte");
                @(negedge clk);
                chk(outport_pin_q[0], 1, "rxpin");
            end
        join
    endtask
    task t_sync;
        begin
            start_tx(8'h81, 2'h2);
            wait_done(3000);
            chk(tog >= 16, 1, "shiftclk");
            chk(drove, 1, "rxdrive");
        end
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 0;
        t_gpio;
        t_tx;
        t_rx;
        t_sync;
        print_verdict;
    end
    initial
    begin
        #2000000;
        err_count = err_count + 1;
        print_verdict;
    end
endmodule
